// *** verif/spip_checker.sv ***
`timescale 1ns/1ps
`include "spip_cfg.svh"
module spip_checker #(
   parameter int NPORT = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic rx_valid,
   input wire logic tx_valid,
   input wire logic rx_done,
   input wire logic rx_drop,
   input wire logic rx_rate_limited,
   input wire logic rx_learn_ok,
   input wire logic tx_done,
   input wire logic tx_rate_limited,
   input wire logic [NPORT-1:0] port_disabled,
   input wire logic [NPORT-1:0] port_forward
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rxa; rx_valid |=> rx_done; endproperty
   a_rxa: assert property (p_rxa) else $error("rx answer late");
   property p_rxq; !rx_valid |=> !rx_done; endproperty
   a_rxq: assert property (p_rxq) else $error("rx answer stray");
   property p_txa; tx_valid |=> tx_done; endproperty
   a_txa: assert property (p_txa) else $error("tx answer late");
   property p_rlr; rx_rate_limited |-> rx_done && !tx_rate_limited; endproperty
   a_rlr: assert property (p_rlr) else $error("rx limit flag");
   property p_rlt; tx_rate_limited |-> tx_done && $past(tx_valid); endproperty
   a_rlt: assert property (p_rlt) else $error("tx limit flag");
   property p_drp; rx_drop |-> rx_done && !rx_learn_ok; endproperty
   a_drp: assert property (p_drp) else $error("drop flag");
   property p_lrn; rx_learn_ok |-> rx_done; endproperty
   a_lrn: assert property (p_lrn) else $error("learn flag");
   property p_dec;
      reg_wr && reg_addr == `SPIP_REG_PORT1 |-> ##2
         port_forward[0] == ($past(reg_wdata[1:0], 2) == 2'b11) &&
         port_disabled[0] == ($past(reg_wdata[1:0], 2) == 2'b00);
   endproperty
   a_dec: assert property (p_dec) else $error("state decode");
   c_rl: cover property (rx_rate_limited);
   c_tl: cover property (tx_rate_limited);
   c_dr: cover property (rx_drop);
endmodule
bind spip_policy spip_checker #(.NPORT(NPORT)) u_spip_checker (.*);

// *** verif/spip_partner.sv ***
`timescale 1ns/1ps
module spip_partner (
   input wire logic clk,
   output logic rx_valid = 1'b0,
   output logic [1:0] rx_port = 2'b00,
   output logic [47:0] rx_dest_addr = 48'h0,
   output logic rx_tagged = 1'b0,
   output logic rx_vlan_found = 1'b0,
   output logic tx_valid = 1'b0,
   output logic [1:0] tx_port = 2'b01,
   output logic [47:0] tx_dest_addr = 48'h0
);
   task automatic rx(input logic [1:0] p, input logic [47:0] d, input logic t, f);
      @(posedge clk);
      {rx_valid, tx_valid, rx_port, rx_dest_addr, rx_tagged, rx_vlan_found} <= {2'b10, p, d, t, f};
   endtask
   task automatic tx(input logic [47:0] d);
      @(posedge clk);
      {rx_valid, tx_valid, tx_dest_addr} <= {2'b01, d};
   endtask
   // Idle address lines flip, so a stale address never looks current
   task automatic idle();
      @(posedge clk);
      {rx_valid, tx_valid, rx_dest_addr, tx_dest_addr} <= {2'b00, ~rx_dest_addr, ~tx_dest_addr};
   endtask
endmodule

// *** verif/spip_tb.sv ***
`timescale 1ns/1ps
module testbench;
   localparam int PRE = 400;
   localparam logic [47:0] MC = 48'h0100_5e00_0001;
   logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v, seed = 32'h26a6be7d;
   logic [47:0] ua, rx_dest_addr, tx_dest_addr;
   logic [1:0] rx_port, tx_port, port_disabled, port_blocked, port_learn, port_forward;
   logic [3:0] port_state_flat;
   logic rx_valid, rx_tagged, rx_vlan_found, tx_valid, rx_done, rx_drop, rx_rate_limited;
   logic rx_learn_ok, tx_done, tx_rate_limited;
   logic [31:0] qrd[$];
   logic [2:0] qpk[$];
   int error_cnt = 0, tests_run = 0, cyc = 0, t0 = 0;
   wire [3:0] dec = {port_forward[0], port_learn[0], port_blocked[0], port_disabled[0]};
   spip_policy u_spip_policy (.*);
   spip_partner u_spip_partner (.*);
   always #2.5 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w)
         qrd.push_back(d);
      u_spip_partner.idle();
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      {reg_wr, reg_rd} <= 2'b00;
   endtask
   // Port 2'b00 means a transmitted packet on port 1
   task automatic pk(input logic [1:0] p, input logic [47:0] d, input logic t, f,
         input logic [2:0] e);
      qpk.push_back(e);
      if (p == 2'b00)
         u_spip_partner.tx(d);
      else
         u_spip_partner.rx(p, d, t, f);
   endtask
   task automatic win(input int k);
      // Drop valid first, or the last packet repeats every cycle
      u_spip_partner.idle();
      while (cyc < t0 + k * PRE + 20)
         @(posedge clk);
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   always @(negedge clk) begin
      if (rd_d)
         cmp("reg_rdata", qrd.pop_front(), reg_rdata);
      if (rx_done === 1'b1)
         cmp("rx", qpk.pop_front(), {rx_drop, rx_rate_limited, rx_learn_ok});
      if (tx_done === 1'b1)
         cmp("tx", qpk.pop_front(), {1'b0, tx_rate_limited, 1'b0});
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      v = rnd();
      ua = {v[15:0], rnd()} & 48'hfeff_ffff_ffff;
      bus(1'b0, 8'h00, 32'h0);
      bus(1'b0, 8'h14, 32'h0);
      bus(1'b1, 8'h04, v);
      bus(1'b0, 8'h04, v);
      $display("end regs");
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, 8'h00, s);
         repeat (3) @(posedge clk);
         cmp("state", 32'h1 << s, dec);
         cmp("state_flat", s, port_state_flat[1:0]);
      end
      bus(1'b1, 8'h00, 32'h7);
      pk(2'b01, ua, 1'b0, 1'b1, 3'b100);
      pk(2'b01, ua, 1'b1, 1'b1, 3'b001);
      bus(1'b1, 8'h00, 32'hb);
      pk(2'b01, ua, 1'b1, 1'b0, 3'b100);
      pk(2'b01, ua, 1'b1, 1'b1, 3'b001);
      bus(1'b1, 8'h00, 32'h13);
      pk(2'b01, ua, 1'b1, 1'b1, 3'b000);
      $display("end flags");
      bus(1'b1, 8'h00, 32'h0062_0013);
      bus(1'b1, 8'h04, 32'h13);
      bus(1'b1, 8'h08, 32'h1);
      pk(2'b01, '1, 1'b1, 1'b1, 3'b010);
      pk(2'b10, '1, 1'b1, 1'b1, 3'b000);
      pk(2'b10, MC, 1'b1, 1'b1, 3'b000);
      bus(1'b1, 8'h0c, PRE);
      t0 = cyc;
      win(1);
      for (int i = 0; i < 4; i++)
         pk(2'b01, '1, 1'b1, 1'b1, {1'b0, i == 3, 1'b0});
      for (int i = 0; i < 3; i++)
         pk(2'b01, MC, 1'b1, 1'b1, {1'b0, i == 2, 1'b0});
      bus(1'b1, 8'h08, 32'h0);
      pk(2'b01, '1, 1'b1, 1'b1, 3'b000);
      bus(1'b1, 8'h08, 32'h1);
      pk(2'b01, '1, 1'b1, 1'b1, 3'b010);
      win(2);
      pk(2'b01, '1, 1'b1, 1'b1, 3'b000);
      bus(1'b1, 8'h08, 32'h9);
      win(3);
      for (int i = 0; i < 4; i++)
         pk(2'b00, '1, 1'b1, 1'b1, {1'b0, i == 3, 1'b0});
      pk(2'b00, MC, 1'b1, 1'b1, 3'b000);
      pk(2'b01, '1, 1'b1, 1'b1, 3'b000);
      bus(1'b0, 8'h08, 32'h9);
      bus(1'b0, 8'h10, 32'h0006_0000);
      u_spip_partner.idle();
      repeat (4) @(posedge clk);
      $display("end rate");
      report_and_stop();
   end
endmodule

// *** verilog/spip_cfg.svh ***
`ifndef SPIP_CFG_SVH
`define SPIP_CFG_SVH
// Register offsets (byte addresses)
`define SPIP_REG_PORT1 8'h00
`define SPIP_REG_PORT2 8'h04
`define SPIP_REG_GLOBAL 8'h08
`define SPIP_REG_PRESCALE 8'h0c
`define SPIP_REG_STATUS 8'h10
// Port control fields
`define SPIP_BC_HI 31
`define SPIP_BC_LO 21
`define SPIP_MC_HI 20
`define SPIP_MC_LO 16
`define SPIP_NO_LEARN 4
`define SPIP_VLAN_CHK 3
`define SPIP_DROP_UNTAG 2
`define SPIP_STATE_HI 1
`define SPIP_STATE_LO 0
// Global control fields
`define SPIP_G_RATE_EN 0
`define SPIP_G_TX_MODE 3
// Prescaler and port control reset value
`define SPIP_PRE_W 20
`define SPIP_PRE_MIN 20'h00010
`define SPIP_PORT_RST 32'h0000_0000
`endif

// *** verilog/spip_pkg.sv ***
package spip_pkg;
   typedef enum logic [1:0] {
      SPIP_DISABLED = 2'b00,
      SPIP_BLOCKED = 2'b01,
      SPIP_LEARN = 2'b10,
      SPIP_FORWARD = 2'b11
   } spip_state_t;
endpackage

// *** verilog/spip_policy.sv ***
`timescale 1ns/1ps
`include "spip_cfg.svh"
// ************************************
// Function
// ************************************
module spip_policy
   import spip_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int BC_W = 11,
   parameter int MC_W = 5
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic rx_valid,
   input wire logic [NPORT-1:0] rx_port,
   input wire logic [47:0] rx_dest_addr,
   input wire logic rx_tagged,
   input wire logic rx_vlan_found,
   input wire logic tx_valid,
   input wire logic [NPORT-1:0] tx_port,
   input wire logic [47:0] tx_dest_addr,
   output logic rx_done,
   output logic rx_drop,
   output logic rx_rate_limited,
   output logic rx_learn_ok,
   output logic tx_done,
   output logic tx_rate_limited,
   output logic [2*NPORT-1:0] port_state_flat,
   output logic [NPORT-1:0] port_disabled,
   output logic [NPORT-1:0] port_blocked,
   output logic [NPORT-1:0] port_learn,
   output logic [NPORT-1:0] port_forward
);
   typedef struct packed {
      logic [NPORT-1:0][31:0] ctl;
      logic [31:0] glob;
      logic [`SPIP_PRE_W-1:0] pre;
      logic [NPORT-1:0][BC_W-1:0] bc_cnt;
      logic [NPORT-1:0][MC_W-1:0] mc_cnt;
      logic [31:0] rdata;
      logic rx_done;
      logic rx_drop;
      logic rx_lim;
      logic rx_learn;
      logic tx_done;
      logic tx_lim;
      logic [NPORT-1:0][1:0] pstate;
      logic [NPORT-1:0] p_dis;
      logic [NPORT-1:0] p_blk;
      logic [NPORT-1:0] p_lrn;
      logic [NPORT-1:0] p_fwd;
      logic [15:0] drop_cnt;
   } spip_st_t;
   spip_st_t st;
   spip_st_t next_st;
   logic pre_pulse;
   spip_prescaler u_pre (
      .clk(clk),
      .rstn(rstn),
      .divider(st.pre),
      .pulse(pre_pulse)
   );
   // ************************************
   // Per-port limit decisions
   // ************************************
   logic [NPORT-1:0] bc_hit;
   logic [NPORT-1:0] mc_hit;
   logic [NPORT-1:0] bc_lim;
   logic [NPORT-1:0] mc_lim;
   logic rx_bc;
   logic rx_mc;
   logic tx_bc;
   logic tx_mc;
   logic tx_mode;
   logic rate_en;
   assign rx_bc = &rx_dest_addr;
   assign rx_mc = rx_dest_addr[40] && !rx_bc;
   assign tx_bc = &tx_dest_addr;
   assign tx_mc = tx_dest_addr[40] && !tx_bc;
   assign tx_mode = st.glob[`SPIP_G_TX_MODE];
   assign rate_en = st.glob[`SPIP_G_RATE_EN];
   genvar gi;
   generate
      for (gi = 0; gi < NPORT; gi++) begin : g_port
         logic pv;
         logic [NPORT-1:0] pp;
         logic pbc;
         logic pmc;
         assign pv = tx_mode ? tx_valid : rx_valid;
         assign pp = tx_mode ? tx_port : rx_port;
         assign pbc = tx_mode ? tx_bc : rx_bc;
         assign pmc = tx_mode ? tx_mc : rx_mc;
         assign bc_hit[gi] = pv && pp[gi] && pbc;
         assign mc_hit[gi] = pv && pp[gi] && pmc;
         assign bc_lim[gi] = rate_en && (st.bc_cnt[gi] == '0)
            && (st.ctl[gi][`SPIP_BC_HI:`SPIP_BC_LO] != '0);
         assign mc_lim[gi] = rate_en && (st.mc_cnt[gi] == '0)
            && (st.ctl[gi][`SPIP_MC_HI:`SPIP_MC_LO] != '0);
      end
   endgenerate
   // ************************************
   // Next state
   // ************************************
   always_comb begin
      logic lim;
      logic drop;
      logic learn;
      logic [31:0] c;
      lim = 1'b0;
      drop = 1'b0;
      learn = 1'b0;
      c = '0;
      next_st = st;
      next_st.rdata = '0;
      next_st.rx_done = 1'b0;
      next_st.rx_drop = 1'b0;
      next_st.rx_lim = 1'b0;
      next_st.rx_learn = 1'b0;
      next_st.tx_done = 1'b0;
      next_st.tx_lim = 1'b0;
      // Register writes
      if (reg_wr) begin
         if (reg_addr == `SPIP_REG_PORT1) begin
            next_st.ctl[0] = reg_wdata;
         end else if (reg_addr == `SPIP_REG_PORT2) begin
            next_st.ctl[NPORT-1] = reg_wdata;
         end else if (reg_addr == `SPIP_REG_GLOBAL) begin
            next_st.glob = reg_wdata;
         end else if (reg_addr == `SPIP_REG_PRESCALE) begin
            next_st.pre = reg_wdata[`SPIP_PRE_W-1:0];
         end
      end
      // Register reads, unmapped reads zero
      if (reg_rd) begin
         if (reg_addr == `SPIP_REG_PORT1) begin
            next_st.rdata = st.ctl[0];
         end else if (reg_addr == `SPIP_REG_PORT2) begin
            next_st.rdata = st.ctl[NPORT-1];
         end else if (reg_addr == `SPIP_REG_GLOBAL) begin
            next_st.rdata = {28'h0000000, st.glob[`SPIP_G_TX_MODE], 2'h0,
               st.glob[`SPIP_G_RATE_EN]};
         end else if (reg_addr == `SPIP_REG_PRESCALE) begin
            next_st.rdata = {12'h000, st.pre};
         end else if (reg_addr == `SPIP_REG_STATUS) begin
            next_st.rdata = {st.drop_cnt, 16'h0000};
         end
      end
      for (int i = 0; i < NPORT; i++) begin
         // count one per matching packet, not below zero
         if (bc_hit[i] && st.bc_cnt[i] != '0) begin
            next_st.bc_cnt[i] = st.bc_cnt[i] - 1'b1;
         end
         if (mc_hit[i] && st.mc_cnt[i] != '0) begin
            next_st.mc_cnt[i] = st.mc_cnt[i] - 1'b1;
         end
         if (pre_pulse) begin
            next_st.bc_cnt[i] = st.ctl[i][`SPIP_BC_HI:`SPIP_BC_LO];
            next_st.mc_cnt[i] = st.ctl[i][`SPIP_MC_HI:`SPIP_MC_LO];
         end
         next_st.pstate[i] = st.ctl[i][`SPIP_STATE_HI:`SPIP_STATE_LO];
         next_st.p_dis[i] = next_st.pstate[i] == SPIP_DISABLED;
         next_st.p_blk[i] = next_st.pstate[i] == SPIP_BLOCKED;
         next_st.p_lrn[i] = next_st.pstate[i] == SPIP_LEARN;
         next_st.p_fwd[i] = next_st.pstate[i] == SPIP_FORWARD;
         if (rx_valid && rx_port[i]) begin
            c = st.ctl[i];
            lim = !tx_mode && (bc_hit[i] && bc_lim[i] || mc_hit[i] && mc_lim[i]);
            drop = (c[`SPIP_DROP_UNTAG] && !rx_tagged)
               || (c[`SPIP_VLAN_CHK] && !rx_vlan_found);
            learn = !c[`SPIP_NO_LEARN] && !drop;
         end
         if (tx_valid && tx_port[i] && tx_mode) begin
            next_st.tx_lim = bc_hit[i] && bc_lim[i] || mc_hit[i] && mc_lim[i];
         end
      end
      next_st.rx_done = rx_valid;
      next_st.rx_drop = rx_valid && drop;
      next_st.rx_lim = rx_valid && lim;
      next_st.rx_learn = rx_valid && learn;
      next_st.tx_done = tx_valid;
      if (rx_valid && (drop || lim) && st.drop_cnt != 16'hffff) begin
         next_st.drop_cnt = st.drop_cnt + 16'h0001;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign reg_rdata = st.rdata;
   assign rx_done = st.rx_done;
   assign rx_drop = st.rx_drop;
   assign rx_rate_limited = st.rx_lim;
   assign rx_learn_ok = st.rx_learn;
   assign tx_done = st.tx_done;
   assign tx_rate_limited = st.tx_lim;
   assign port_state_flat = st.pstate;
   assign port_disabled = st.p_dis;
   assign port_blocked = st.p_blk;
   assign port_learn = st.p_lrn;
   assign port_forward = st.p_fwd;
endmodule

// *** verilog/spip_prescaler.sv ***
`timescale 1ns/1ps
`include "spip_cfg.svh"
module spip_prescaler
   import spip_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [`SPIP_PRE_W-1:0] divider,
   output logic pulse
);
   typedef struct packed {
      logic [`SPIP_PRE_W-1:0] cnt;
      logic pulse;
   } spip_pre_st_t;
   spip_pre_st_t st;
   spip_pre_st_t next_st;
   // ************************************
   // Divider
   // ************************************
   always_comb begin
      next_st = st;
      next_st.pulse = 1'b0;
      if (divider == '0) begin
         next_st.cnt = '0;
      end else if (st.cnt >= divider - 1'b1) begin
         next_st.cnt = '0;
         next_st.pulse = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign pulse = st.pulse;
endmodule
